// ===== rtl/fqr_pkg.sv
package fqr_pkg;

  // ==========================================================
  // widths
  localparam int unsigned ADDR_W = 22;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned QOFF_W = 8;

  // ==========================================================
  // host commands, taken from the low data byte of a write
  localparam logic [7:0] CMD_QUERY      = 8'h98;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;

  // ==========================================================
  // query structure word offsets (section starts and fields)
  localparam logic [7:0] OFF_MAKER_ID     = 8'h00;
  localparam logic [7:0] OFF_PART_ID      = 8'h01;
  localparam logic [7:0] OFF_ID_STRING    = 8'h10;
  localparam logic [7:0] OFF_STR_CHAR1    = 8'h11;
  localparam logic [7:0] OFF_STR_CHAR2    = 8'h12;
  localparam logic [7:0] OFF_CMDSET_LO    = 8'h13;
  localparam logic [7:0] OFF_CMDSET_HI    = 8'h14;
  localparam logic [7:0] OFF_EXT_ADDR_LO  = 8'h15;
  localparam logic [7:0] OFF_EXT_ADDR_HI  = 8'h16;
  localparam logic [7:0] OFF_ALT_FIRST    = 8'h17;
  localparam logic [7:0] OFF_ALT_ID_HI    = 8'h18;
  localparam logic [7:0] OFF_ALT_ADDR_LO  = 8'h19;
  localparam logic [7:0] OFF_ALT_LAST     = 8'h1a;
  localparam logic [7:0] OFF_SYS_IF       = 8'h1b;
  localparam logic [7:0] OFF_LOGIC_MAX    = 8'h1c;
  localparam logic [7:0] OFF_PROG_MIN     = 8'h1d;
  localparam logic [7:0] OFF_PROG_MAX     = 8'h1e;
  localparam logic [7:0] OFF_TYP_WORD     = 8'h1f;
  localparam logic [7:0] OFF_TYP_MULTI    = 8'h20;
  localparam logic [7:0] OFF_TYP_BLOCK    = 8'h21;
  localparam logic [7:0] OFF_TYP_CHIP     = 8'h22;
  localparam logic [7:0] OFF_MAX_WORD     = 8'h23;
  localparam logic [7:0] OFF_MAX_MULTI    = 8'h24;
  localparam logic [7:0] OFF_MAX_BLOCK    = 8'h25;
  localparam logic [7:0] OFF_MAX_CHIP     = 8'h26;
  localparam logic [7:0] OFF_GEOMETRY     = 8'h27;
  localparam logic [7:0] OFF_SECURITY     = 8'h80;
  localparam logic [7:0] OFF_UNIQUE_FIRST = 8'h81;
  localparam logic [7:0] OFF_UNIQUE_LAST  = 8'h88;
  localparam logic [7:0] OFF_OTP_FIRST    = 8'h89;
  localparam logic [7:0] OFF_OTP_LAST     = 8'h98;

  // ==========================================================
  // query word values (low byte only)
  localparam logic [7:0] VAL_STR_CHAR0    = 8'h51;
  localparam logic [7:0] VAL_STR_CHAR1    = 8'h52;
  localparam logic [7:0] VAL_STR_CHAR2    = 8'h59;
  localparam logic [7:0] VAL_CMDSET_LO    = 8'h03;
  localparam logic [7:0] VAL_EXT_ADDR_LO  = 8'h39;
  localparam logic [7:0] VAL_LOGIC_MIN    = 8'h17;
  localparam logic [7:0] VAL_LOGIC_MAX    = 8'h20;
  localparam logic [7:0] VAL_PROG_MIN     = 8'h85;
  localparam logic [7:0] VAL_PROG_MAX     = 8'h95;
  localparam logic [7:0] VAL_TYP_WORD     = 8'h04;
  localparam logic [7:0] VAL_TYP_BLOCK    = 8'h0a;
  localparam logic [7:0] VAL_MAX_WORD     = 8'h03;
  localparam logic [7:0] VAL_MAX_BLOCK    = 8'h02;
  localparam logic [7:0] VAL_ZERO         = 8'h00;

  // ==========================================================
  // types
  typedef enum logic {
    FQR_MODE_ARRAY,
    FQR_MODE_QUERY
  } fqr_mode_e;

  typedef struct packed {
    logic              rd_en;
    logic              wr_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wr_data;
  } fqr_req_s;

  typedef struct packed {
    logic [7:0] high_data_byte_lines;
    logic [7:0] low_data_byte_lines;
  } fqr_word_s;

  typedef struct packed {
    fqr_mode_e mode;
    logic      rd_valid;
    fqr_word_s rd_word;
  } fqr_state_s;

  localparam fqr_word_s  WORD_RESET  = '{8'h00, 8'h00};
  localparam fqr_state_s STATE_RESET = '{FQR_MODE_ARRAY, 1'b0, WORD_RESET};

endpackage

// ===== rtl/fqr_responder.sv
`timescale 1ns/10ps
`default_nettype none

module fqr_responder #(
  // arbitrary neutral identity values
  parameter logic [7:0]   MAKER_CODE = 8'h5a,
  parameter logic [7:0]   PART_CODE  = 8'h3c,
  // security contents fixed at manufacture; arbitrary defaults
  parameter logic [7:0]   LOCK_REG   = 8'h02,
  parameter logic [63:0]  UNIQUE_NUM = 64'h0123_4567_89ab_cdef,
  parameter logic [127:0] OTP_CELLS  = {128{1'b1}}
) (
  input  wire logic                         mclk_i,
  input  wire logic                         rst_b_i,
  input  wire fqr_pkg::fqr_req_s            req_i,
  input  wire logic [fqr_pkg::DATA_W-1:0]   array_data_i,
  output var  fqr_pkg::fqr_word_s           rd_data_o,
  output logic                              rd_valid_o,
  output logic                              query_mode_o
);

  // ==========================================================
  // query structure lookup
  function automatic logic [7:0] query_byte(input logic [7:0] off);
    logic [7:0] idx;
    idx = 8'h00;
    query_byte = fqr_pkg::VAL_ZERO;
    case (off)
      fqr_pkg::OFF_MAKER_ID:    query_byte = MAKER_CODE;
      fqr_pkg::OFF_PART_ID:     query_byte = PART_CODE;
      fqr_pkg::OFF_ID_STRING:   query_byte = fqr_pkg::VAL_STR_CHAR0;
      fqr_pkg::OFF_STR_CHAR1:   query_byte = fqr_pkg::VAL_STR_CHAR1;
      fqr_pkg::OFF_STR_CHAR2:   query_byte = fqr_pkg::VAL_STR_CHAR2;
      fqr_pkg::OFF_CMDSET_LO:   query_byte = fqr_pkg::VAL_CMDSET_LO;
      fqr_pkg::OFF_CMDSET_HI:   query_byte = fqr_pkg::VAL_ZERO;
      fqr_pkg::OFF_EXT_ADDR_LO: query_byte = fqr_pkg::VAL_EXT_ADDR_LO;
      fqr_pkg::OFF_EXT_ADDR_HI: query_byte = fqr_pkg::VAL_ZERO;
      fqr_pkg::OFF_ALT_FIRST,
      fqr_pkg::OFF_ALT_ID_HI,
      fqr_pkg::OFF_ALT_ADDR_LO,
      fqr_pkg::OFF_ALT_LAST:    query_byte = fqr_pkg::VAL_ZERO;
      fqr_pkg::OFF_SYS_IF:      query_byte = fqr_pkg::VAL_LOGIC_MIN;
      fqr_pkg::OFF_LOGIC_MAX:   query_byte = fqr_pkg::VAL_LOGIC_MAX;
      fqr_pkg::OFF_PROG_MIN:    query_byte = fqr_pkg::VAL_PROG_MIN;
      fqr_pkg::OFF_PROG_MAX:    query_byte = fqr_pkg::VAL_PROG_MAX;
      fqr_pkg::OFF_TYP_WORD:    query_byte = fqr_pkg::VAL_TYP_WORD;
      fqr_pkg::OFF_TYP_BLOCK:   query_byte = fqr_pkg::VAL_TYP_BLOCK;
      fqr_pkg::OFF_MAX_WORD:    query_byte = fqr_pkg::VAL_MAX_WORD;
      fqr_pkg::OFF_MAX_BLOCK:   query_byte = fqr_pkg::VAL_MAX_BLOCK;
      fqr_pkg::OFF_TYP_MULTI,
      fqr_pkg::OFF_TYP_CHIP,
      fqr_pkg::OFF_MAX_MULTI,
      fqr_pkg::OFF_MAX_CHIP:    query_byte = fqr_pkg::VAL_ZERO;
      fqr_pkg::OFF_SECURITY:    query_byte = LOCK_REG;
      default: begin
        // reserved and uncovered words stay zero
        if (off >= fqr_pkg::OFF_UNIQUE_FIRST && off <= fqr_pkg::OFF_UNIQUE_LAST) begin
          // unique number, low byte first; parameter so nothing can rewrite it
          idx = off - fqr_pkg::OFF_UNIQUE_FIRST;
          query_byte = UNIQUE_NUM[{idx[2:0], 3'b000} +: 8];
        end else if (off >= fqr_pkg::OFF_OTP_FIRST && off <= fqr_pkg::OFF_OTP_LAST) begin
          idx = off - fqr_pkg::OFF_OTP_FIRST;
          query_byte = OTP_CELLS[{idx[3:0], 3'b000} +: 8];
        end
      end
    endcase
  endfunction

  function automatic logic is_cmd(input fqr_pkg::fqr_req_s r, input logic [7:0] c);
    is_cmd = r.wr_en && (r.wr_data[7:0] == c);
  endfunction

  // ==========================================================
  // state
  fqr_pkg::fqr_state_s state_ff;
  fqr_pkg::fqr_state_s nxt_state;

  always_comb begin
    nxt_state = state_ff;
    nxt_state.rd_valid = req_i.rd_en;
    if (req_i.rd_en) begin
      // reads use the mode in force before any write in the same cycle
      if (state_ff.mode == fqr_pkg::FQR_MODE_QUERY) begin
        nxt_state.rd_word.low_data_byte_lines  = query_byte(req_i.addr[7:0]);
        nxt_state.rd_word.high_data_byte_lines = 8'h00;
      end else begin
        nxt_state.rd_word = fqr_pkg::fqr_word_s'(array_data_i);
      end
    end
    case (state_ff.mode)
      fqr_pkg::FQR_MODE_ARRAY: begin
        if (is_cmd(req_i, fqr_pkg::CMD_QUERY)) begin
          nxt_state.mode = fqr_pkg::FQR_MODE_QUERY;
        end
      end
      fqr_pkg::FQR_MODE_QUERY: begin
        if (is_cmd(req_i, fqr_pkg::CMD_READ_ARRAY)) begin
          nxt_state.mode = fqr_pkg::FQR_MODE_ARRAY;
        end
        // other write data is ignored, query contents are constant
      end
      default: begin
        nxt_state.mode = fqr_pkg::FQR_MODE_ARRAY;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_ff <= fqr_pkg::STATE_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign rd_data_o    = state_ff.rd_word;
  assign rd_valid_o   = state_ff.rd_valid;
  assign query_mode_o = (state_ff.mode == fqr_pkg::FQR_MODE_QUERY);

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_qrd(logic [7:0] a);
    req_i.rd_en && (state_ff.mode == fqr_pkg::FQR_MODE_QUERY) && (req_i.addr[7:0] == a);
  endsequence

  sequence s_answer(logic [7:0] v);
    rd_valid_o && (rd_data_o.low_data_byte_lines == v) && (rd_data_o.high_data_byte_lines == 8'h00);
  endsequence

  a_query_entry: assert property (
    (state_ff.mode == fqr_pkg::FQR_MODE_ARRAY) && is_cmd(req_i, fqr_pkg::CMD_QUERY)
      |=> query_mode_o)
    else $error("query command did not enter query mode");

  a_query_readback: assert property (
    req_i.rd_en && query_mode_o
      |=> rd_valid_o && (rd_data_o.low_data_byte_lines == query_byte($past(req_i.addr[7:0]))))
    else $error("query read returned wrong word");

  a_high_byte_zero: assert property (
    rd_valid_o && $past(query_mode_o) |-> (rd_data_o.high_data_byte_lines == 8'h00))
    else $error("high byte lines not zero in query mode");

  a_array_exit: assert property (
    query_mode_o && is_cmd(req_i, fqr_pkg::CMD_READ_ARRAY)
      ##1 (req_i.rd_en && !req_i.wr_en)
      |=> !query_mode_o && (rd_data_o == fqr_pkg::fqr_word_s'($past(array_data_i))))
    else $error("read array did not restore array reads");

  a_array_passthru: assert property (
    req_i.rd_en && !query_mode_o |=> rd_valid_o && (rd_data_o == $past(array_data_i)))
    else $error("array read data mismatch");

  a_unique_first: assert property (
    s_qrd(fqr_pkg::OFF_UNIQUE_FIRST) |=> s_answer(UNIQUE_NUM[7:0]))
    else $error("unique number low byte wrong");

  a_unique_last: assert property (
    s_qrd(fqr_pkg::OFF_UNIQUE_LAST) |=> s_answer(UNIQUE_NUM[63:56]))
    else $error("unique number high byte wrong");

  a_section_heads: assert property (
    s_qrd(fqr_pkg::OFF_SYS_IF)
      |=> s_answer(fqr_pkg::VAL_LOGIC_MIN))
    else $error("system interface head word wrong");

  a_string_head: assert property (
    s_qrd(fqr_pkg::OFF_ID_STRING)
      |=> s_answer(fqr_pkg::VAL_STR_CHAR0))
    else $error("id string head word wrong");

  a_geometry_head: assert property (
    s_qrd(fqr_pkg::OFF_GEOMETRY)
      |=> s_answer(fqr_pkg::VAL_ZERO))
    else $error("geometry head word wrong");

  a_security_head: assert property (
    s_qrd(fqr_pkg::OFF_SECURITY) |=> s_answer(LOCK_REG))
    else $error("lock register word wrong");

  a_maker_code: assert property (
    s_qrd(fqr_pkg::OFF_MAKER_ID) |=> s_answer(MAKER_CODE))
    else $error("maker code wrong");

  a_reserved_low: assert property (
    req_i.rd_en && query_mode_o && (req_i.addr[7:0] >= 8'h02) && (req_i.addr[7:0] <= 8'h0f)
      |=> s_answer(8'h00))
    else $error("reserved low word not zero");

  a_qry_string: assert property (
    s_qrd(8'h10) ##1 s_qrd(8'h11) ##1 s_qrd(8'h12)
      |-> $past(rd_data_o.low_data_byte_lines, 1) == fqr_pkg::VAL_STR_CHAR0
          ##1 s_answer(fqr_pkg::VAL_STR_CHAR2))
    else $error("query string wrong");

  a_string_char1: assert property (
    s_qrd(8'h11) |=> s_answer(fqr_pkg::VAL_STR_CHAR1))
    else $error("second string char wrong");

  a_cmdset_id: assert property (
    s_qrd(8'h13) ##1 s_qrd(8'h14) |-> s_answer(8'h03) ##1 s_answer(8'h00))
    else $error("command set id wrong");

  a_ext_table: assert property (
    s_qrd(8'h15) ##1 s_qrd(8'h16) |-> s_answer(8'h39) ##1 s_answer(8'h00))
    else $error("extended table address wrong");

  a_no_alternate: assert property (
    req_i.rd_en && query_mode_o && (req_i.addr[7:0] >= 8'h17) && (req_i.addr[7:0] <= 8'h1a)
      |=> s_answer(8'h00))
    else $error("alternate field not zero");

  a_logic_supply: assert property (
    s_qrd(8'h1c) |=> s_answer(8'h20))
    else $error("logic supply max wrong");

  a_prog_supply: assert property (
    s_qrd(8'h1d) ##1 s_qrd(8'h1e) |-> s_answer(8'h85) ##1 s_answer(8'h95))
    else $error("program supply range wrong");

  a_typ_timeouts: assert property (
    s_qrd(fqr_pkg::OFF_TYP_WORD)
      |=> s_answer(fqr_pkg::VAL_TYP_WORD))
    else $error("typical word program timeout wrong");

  a_typ_erase: assert property (
    s_qrd(fqr_pkg::OFF_TYP_BLOCK)
      |=> s_answer(fqr_pkg::VAL_TYP_BLOCK))
    else $error("typical block erase timeout wrong");

  a_max_timeouts: assert property (
    s_qrd(fqr_pkg::OFF_MAX_WORD)
      |=> s_answer(fqr_pkg::VAL_MAX_WORD))
    else $error("maximum word program factor wrong");

  a_max_erase: assert property (
    s_qrd(fqr_pkg::OFF_MAX_BLOCK)
      |=> s_answer(fqr_pkg::VAL_MAX_BLOCK))
    else $error("maximum block erase factor wrong");

  a_zero_timeouts: assert property (
    req_i.rd_en && query_mode_o
      && ((req_i.addr[7:0] == 8'h20) || (req_i.addr[7:0] == 8'h22)
          || (req_i.addr[7:0] == 8'h24) || (req_i.addr[7:0] == 8'h26))
      |=> s_answer(8'h00))
    else $error("multi or chip timeout not zero");

  a_other_writes: assert property (
    req_i.wr_en && (req_i.wr_data[7:0] != fqr_pkg::CMD_QUERY)
      && (req_i.wr_data[7:0] != fqr_pkg::CMD_READ_ARRAY)
      |=> $stable(query_mode_o))
    else $error("stray write changed mode");

  a_geometry_zero: assert property (
    req_i.rd_en && query_mode_o && (req_i.addr[7:0] >= 8'h27) && (req_i.addr[7:0] <= 8'h7f)
      |=> s_answer(8'h00))
    else $error("uncovered query word not zero");

  // ==========================================================
  // mode, strobe and read data hold checks
  a_query_stays: assert property (
    query_mode_o && is_cmd(req_i, fqr_pkg::CMD_QUERY)
      |=> query_mode_o)
    else $error("repeated query command left query mode");

  a_array_stays: assert property (
    !query_mode_o && is_cmd(req_i, fqr_pkg::CMD_READ_ARRAY)
      |=> !query_mode_o)
    else $error("read array command in array mode changed mode");

  a_mode_hold: assert property (
    !req_i.wr_en
      |=> $stable(query_mode_o))
    else $error("mode changed without a write");

  a_valid_idle: assert property (
    !req_i.rd_en
      |=> !rd_valid_o)
    else $error("read strobe without a read");

  a_data_hold: assert property (
    !req_i.rd_en
      |=> $stable(rd_data_o))
    else $error("read data changed without a read");

  // ==========================================================
  // table word checks
  a_part_code: assert property (
    s_qrd(fqr_pkg::OFF_PART_ID)
      |=> s_answer(PART_CODE))
    else $error("part code wrong");

  a_string_char2: assert property (
    s_qrd(fqr_pkg::OFF_STR_CHAR2)
      |=> s_answer(fqr_pkg::VAL_STR_CHAR2))
    else $error("third string char wrong");

  a_cmdset_low: assert property (
    s_qrd(fqr_pkg::OFF_CMDSET_LO)
      |=> s_answer(fqr_pkg::VAL_CMDSET_LO))
    else $error("command set id low word wrong");

  a_ext_low: assert property (
    s_qrd(fqr_pkg::OFF_EXT_ADDR_LO)
      |=> s_answer(fqr_pkg::VAL_EXT_ADDR_LO))
    else $error("extended table address low word wrong");

  a_upper_zero: assert property (
    req_i.rd_en && query_mode_o && (req_i.addr[7:0] > fqr_pkg::OFF_OTP_LAST)
      |=> s_answer(fqr_pkg::VAL_ZERO))
    else $error("word above otp area not zero");

  // ==========================================================
  // security word checks
  // one check per unique number byte so a swapped byte order cannot slip through
  a_unique_word1: assert property (
    s_qrd(8'h82)
      |=> s_answer(UNIQUE_NUM[15:8]))
    else $error("unique number byte 1 wrong");

  a_unique_word2: assert property (
    s_qrd(8'h83)
      |=> s_answer(UNIQUE_NUM[23:16]))
    else $error("unique number byte 2 wrong");

  a_unique_word3: assert property (
    s_qrd(8'h84)
      |=> s_answer(UNIQUE_NUM[31:24]))
    else $error("unique number byte 3 wrong");

  a_unique_word4: assert property (
    s_qrd(8'h85)
      |=> s_answer(UNIQUE_NUM[39:32]))
    else $error("unique number byte 4 wrong");

  a_unique_word5: assert property (
    s_qrd(8'h86)
      |=> s_answer(UNIQUE_NUM[47:40]))
    else $error("unique number byte 5 wrong");

  a_unique_word6: assert property (
    s_qrd(8'h87)
      |=> s_answer(UNIQUE_NUM[55:48]))
    else $error("unique number byte 6 wrong");

  a_otp_first: assert property (
    s_qrd(fqr_pkg::OFF_OTP_FIRST)
      |=> s_answer(OTP_CELLS[7:0]))
    else $error("first otp word wrong");

  a_otp_last: assert property (
    s_qrd(fqr_pkg::OFF_OTP_LAST)
      |=> s_answer(OTP_CELLS[127:120]))
    else $error("last otp word wrong");

endmodule

`default_nettype wire

// ===== verif/fqr_array_model.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// array side: answers reads with an address-derived word
module fqr_array_model (
  input  wire logic              mclk_i,
  input  wire logic              rst_b_i,
  input  wire fqr_pkg::fqr_req_s req_i,
  output logic [15:0]            data_o
);
  logic [15:0] churn_ff;

  // idle bus keeps changing so a stale word cannot pass for a fresh one
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      churn_ff <= 16'h5a5a;
    end else begin
      churn_ff <= ~churn_ff + 16'h0001;
    end
  end

  assign data_o = req_i.rd_en ? (req_i.addr[15:0] ^ 16'hc3a5) : churn_ff;
endmodule

`default_nettype wire

// ===== verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  // identity and security contents: arbitrary values
  localparam logic [7:0]   MAKER = 8'h6b;
  localparam logic [7:0]   PART  = 8'h4e;
  localparam logic [7:0]   LOCK  = 8'h01;
  localparam logic [63:0]  UNIQ  = 64'hfedc_ba98_7654_3210;
  localparam logic [127:0] OTP   = 128'h0f1e_2d3c_4b5a_6978_8796_a5b4_c3d2_e1f0;

  logic               mclk_i;
  logic               rst_b_i;
  fqr_pkg::fqr_req_s  req_i;
  logic [15:0]        array_data_i;
  fqr_pkg::fqr_word_s rd_data_o;
  logic               rd_valid_o;
  logic               query_mode_o;
  int                 n_errors;
  int                 compares;

  fqr_responder #(.MAKER_CODE(MAKER), .PART_CODE(PART), .LOCK_REG(LOCK),
                  .UNIQUE_NUM(UNIQ), .OTP_CELLS(OTP)) dut (
    .mclk_i       (mclk_i),
    .rst_b_i      (rst_b_i),
    .req_i        (req_i),
    .array_data_i (array_data_i),
    .rd_data_o    (rd_data_o),
    .rd_valid_o   (rd_valid_o),
    .query_mode_o (query_mode_o)
  );

  fqr_array_model u_array (
    .mclk_i  (mclk_i),
    .rst_b_i (rst_b_i),
    .req_i   (req_i),
    .data_o  (array_data_i)
  );

  // ==========================================================
  // expected contents
  function automatic logic [15:0] exp_q(input logic [7:0] o);
    logic [7:0] v;
    v = 8'h00;
    case (o)
      8'h00: v = MAKER;
      8'h01: v = PART;
      8'h10: v = 8'h51;
      8'h11: v = 8'h52;
      8'h12: v = 8'h59;
      8'h13: v = 8'h03;
      8'h15: v = 8'h39;
      8'h1b: v = 8'h17;
      8'h1c: v = 8'h20;
      8'h1d: v = 8'h85;
      8'h1e: v = 8'h95;
      8'h1f: v = 8'h04;
      8'h21: v = 8'h0a;
      8'h23: v = 8'h03;
      8'h25: v = 8'h02;
      8'h80: v = LOCK;
      default: begin
        if (o >= 8'h81 && o <= 8'h88) begin
          v = UNIQ[(int'(o) - 129) * 8 +: 8];
        end else if (o >= 8'h89 && o <= 8'h98) begin
          v = OTP[(int'(o) - 137) * 8 +: 8];
        end
      end
    endcase
    return {8'h00, v};
  endfunction

  // ==========================================================
  // compares and bus tasks
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t word got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t flag got %b exp %b", $time, got, exp);
    end
  endtask

  // called at a falling edge; request is taken at the next rising edge
  task automatic drive(input logic rd, input logic wr, input logic [21:0] a,
                       input logic [15:0] d);
    req_i.rd_en   = rd;
    req_i.wr_en   = wr;
    req_i.addr    = a;
    req_i.wr_data = d;
    @(negedge mclk_i);
  endtask

  task automatic idle();
    drive(1'b0, 1'b0, 22'h000000, 16'h0000);
    chk_bit(rd_valid_o, 1'b0);
  endtask

  task automatic read_w(input logic [21:0] a, input logic [15:0] exp);
    drive(1'b1, 1'b0, a, 16'h0000);
    chk_bit(rd_valid_o, 1'b1);
    chk_word(rd_data_o, exp);
  endtask

  task automatic results();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end

  initial begin
    repeat (5000) @(posedge mclk_i);
    n_errors++;
    results();
  end

  // ==========================================================
  // tests
  initial begin
    n_errors = 0;
    compares = 0;
    rst_b_i  = 1'b0;
    req_i    = '0;
    repeat (16) @(negedge mclk_i);
    chk_word(rd_data_o, 16'h0000);
    chk_bit(query_mode_o, 1'b0);
    rst_b_i = 1'b1;
    @(negedge mclk_i);
    $display("test reset done");

    read_w(22'h012345, 16'h2345 ^ 16'hc3a5);
    drive(1'b0, 1'b1, 22'h000000, 16'h00ff);
    read_w(22'h000010, 16'h0010 ^ 16'hc3a5);
    // read beside the command still sees array mode
    drive(1'b1, 1'b1, 22'h000020, 16'h0098);
    chk_word(rd_data_o, 16'h0020 ^ 16'hc3a5);
    chk_bit(query_mode_o, 1'b1);
    $display("test enter done");

    // upper address bits set: only the low offset selects the word
    for (int i = 0; i < 256; i++) begin
      read_w({14'h0b5, i[7:0]}, exp_q(i[7:0]));
    end
    idle();
    $display("test table done");

    drive(1'b0, 1'b1, 22'h000081, 16'h0040);
    drive(1'b0, 1'b1, 22'h000085, 16'h0000);
    drive(1'b0, 1'b1, 22'h000088, 16'hff60);
    drive(1'b0, 1'b1, 22'h000010, 16'h0098);
    chk_bit(query_mode_o, 1'b1);
    for (int i = 8'h80; i < 8'h89; i++) begin
      read_w({14'h0000, i[7:0]}, exp_q(i[7:0]));
    end
    $display("test refuse done");

    // leave with a read in the same cycle: that read still sees query data
    drive(1'b1, 1'b1, 22'h000010, 16'h00ff);
    chk_word(rd_data_o, 16'h0051);
    chk_bit(query_mode_o, 1'b0);
    read_w(22'h000010, 16'h0010 ^ 16'hc3a5);
    idle();
    $display("test leave done");

    drive(1'b0, 1'b1, 22'h000000, 16'h0098);
    chk_bit(query_mode_o, 1'b1);
    rst_b_i = 1'b0;
    // drop the command, or it would be taken again after release
    req_i   = '0;
    #5;
    chk_bit(query_mode_o, 1'b0);
    @(negedge mclk_i);
    rst_b_i = 1'b1;
    @(negedge mclk_i);
    read_w(22'h000011, 16'h0011 ^ 16'hc3a5);
    idle();
    $display("test midreset done");
    results();
  end
endmodule

`default_nettype wire
